// ==== core/contact_input_function_mapper.v ====
// contact input function mapper: turns debounced contact edges into loop actions
// How it works
// - contacts come from inputs, outputs or one of three internal switch groups
// - a global halt contact stops both loops when asserted
// - a global run contact starts both loops when asserted
// - per-loop run/stop: rising edge stops the loop, falling edge runs it
// - run/stop at most two loops per block; cascade accepts loop 2 only
// - remote/local: rising remote, falling local; cascade accepts loop 1 only
// - with program control on, remote/local toggles program and local operation
// - auto/man: rising auto, falling manual; refused in cascade control
// - cascade transfer moves loops 1-2 into cascade operation, cascade only
// - auto transfer moves loops 1-2 into auto operation, cascade only
// - manual transfer moves loops 1-2 to manual; once per block, never block 3
// - setpoint number is the binary value of up to four select bits, 1 to 8
// - setpoint bits only on inputs three to six or expansion nine to twelve
// - msb placed on input six fills the lower bits below it automatically
// - only one setpoint selection group exists in the whole device
// - program begin, clear, hold and advance are accepted only under program control
// - pattern number is the binary value of up to five bits, 1 to 30
// - pattern bits only on inputs one to five; auto fill from a highest pattern
`timescale 1ns/100ps
`default_nettype none
`include "contact_mapper_regs.vh"
module contact_input_function_mapper #(
    parameter BLOCK_ID = 1,
    parameter STABLE_CYC = `DEBOUNCE_CYC
) (
    input wire CORE_CLK,
    input wire RST_N,
    input wire [5:0] CTL_BLOCK_INPUTS,
    input wire [5:0] CTL_BLOCK_OUTPUTS,
    input wire [5:0] INTERNAL_SWITCH_GROUP_A,
    input wire [5:0] INTERNAL_SWITCH_GROUP_B,
    input wire [5:0] INTERNAL_SWITCH_GROUP_C,
    input wire [3:0] EXPANSION_INPUTS,
    input wire [2:0] SOURCE_SELECT,
    input wire CASCADE_CONTROL,
    input wire PROGRAM_CONTROL,
    input wire SP_ON_EXPANSION,
    input wire CFG_WRITE,
    input wire [2:0] CFG_INDEX,
    input wire [4:0] CFG_FUNCTION,
    input wire CFG_SP_AUTO,
    input wire [1:0] CFG_SP_MSB,
    input wire CFG_PAT_AUTO,
    input wire [4:0] CFG_PAT_HIGHEST,
    output reg CFG_REFUSED,
    output reg CFG_BUSY,
    output reg [1:0] LOOP_RUN,
    output reg [1:0] LOOP_REMOTE,
    output reg [1:0] LOOP_PROGRAM,
    output reg [1:0] LOOP_AUTO,
    output reg [1:0] CASCADE_STATE,
    output reg [3:0] SETPOINT_NUMBER,
    output reg [4:0] PATTERN_NUMBER,
    output reg PROGRAM_BEGIN,
    output reg PROGRAM_CLEAR,
    output reg PROGRAM_HOLD,
    output reg PROGRAM_ADVANCE
);
    localparam ST_IDLE = 1'b0;
    localparam ST_FILL = 1'b1;

    reg [5:0] group_mux;
    wire [9:0] lvl;
    wire [9:0] rise;
    wire [9:0] fall;
    wire [6*`FN_WIDTH-1:0] tbl;
    reg state_r;
    reg state_nxt;
    reg [2:0] fill_idx_r;
    reg [2:0] fill_idx_nxt;
    reg [4:0] fill_code_r;
    reg [4:0] fill_code_nxt;
    reg [2:0] fill_left_r;
    reg [2:0] fill_left_nxt;
    reg wr_en;
    reg [2:0] wr_idx;
    reg [4:0] wr_code;
    reg refused_nxt;
    reg [3:0] sp_raw;
    reg [4:0] pat_raw;
    integer k, m;

    // code held at one table slot
    function [4:0] entry;
        input [6*`FN_WIDTH-1:0] t;
        input [2:0] idx;
        begin
            entry = t[idx*`FN_WIDTH +: `FN_WIDTH];
        end
    endfunction

    // true when some slot other than idx holds a code in [lo, hi]
    function other_holds;
        input [6*`FN_WIDTH-1:0] t;
        input [2:0] idx;
        input [4:0] lo;
        input [4:0] hi;
        integer j;
        begin
            other_holds = 1'b0;
            for (j = 0; j < 6; j = j + 1)
            begin
                if (j[2:0] != idx && entry(t, j[2:0]) >= lo && entry(t, j[2:0]) <= hi)
                    other_holds = 1'b1;
            end
        end
    endfunction

    // whether a code may be placed on a slot under the current modes
    function legal;
        input [6*`FN_WIDTH-1:0] t;
        input [2:0] idx;
        input [4:0] code;
        input cas;
        input prog;
        input sp_exp;
        begin
            case (code)
                `FN_NONE, `FN_GLOBAL_HALT, `FN_GLOBAL_RUN:
                    legal = 1'b1;
                `FN_RUN_STOP_1:
                    legal = ~cas;
                `FN_RUN_STOP_2:
                    legal = 1'b1;
                `FN_REM_LOC_1:
                    legal = 1'b1;
                `FN_REM_LOC_2:
                    legal = ~cas;
                `FN_AUTO_MAN_1, `FN_AUTO_MAN_2:
                    legal = ~cas;
                `FN_CASCADE_XFER, `FN_AUTO_XFER:
                    legal = cas;
                `FN_MANUAL_XFER:
                    legal = cas && BLOCK_ID != 3 &&
                        !other_holds(t, idx, `FN_MANUAL_XFER, `FN_MANUAL_XFER);
                `FN_PROG_BEGIN, `FN_PROG_CLEAR, `FN_PROG_HOLD, `FN_PROG_ADVANCE:
                    legal = prog;
                default:
                begin
                    if (code >= `FN_SP_BIT0 && code <= `FN_SP_BIT3)
                        legal = !sp_exp && idx >= `IDX_INPUT_THREE;
                    else if (code >= `FN_PAT_BIT0 && code <= `FN_PAT_BIT4)
                        legal = prog && idx <= `IDX_INPUT_FIVE;
                    else
                        legal = 1'b0;
                end
            endcase
        end
    endfunction

    // pattern bits needed to reach the highest pattern
    function [2:0] bits_for;
        input [4:0] highest;
        begin
            if (highest <= 5'h01)
                bits_for = 3'h1;
            else if (highest <= 5'h03)
                bits_for = 3'h2;
            else if (highest <= 5'h07)
                bits_for = 3'h3;
            else if (highest <= 5'h0f)
                bits_for = 3'h4;
            else
                bits_for = 3'h5;
        end
    endfunction

    // contact source group; a switch of groups can itself produce edges
    always @*
    begin
        case (SOURCE_SELECT)
            `SRC_CTL_INPUTS: group_mux = CTL_BLOCK_INPUTS;
            `SRC_CTL_OUTPUTS: group_mux = CTL_BLOCK_OUTPUTS;
            `SRC_SWITCH_A: group_mux = INTERNAL_SWITCH_GROUP_A;
            `SRC_SWITCH_B: group_mux = INTERNAL_SWITCH_GROUP_B;
            `SRC_SWITCH_C: group_mux = INTERNAL_SWITCH_GROUP_C;
            default: group_mux = 6'h00;
        endcase
    end

    // six group contacts then four expansion contacts, each filtered
    genvar g;
    generate
        for (g = 0; g < 10; g = g + 1)
        begin : filt
            contact_debounce #(
                .STABLE_CYC(STABLE_CYC)
            ) u_deb (
                .clk(CORE_CLK),
                .rst_n(RST_N),
                .raw(g < 6 ? group_mux[g % 6] : EXPANSION_INPUTS[(g + 2) % 4]),
                .level_r(lvl[g]),
                .rise_r(rise[g]),
                .fall_r(fall[g])
            );
        end
    endgenerate

    function_table #(
        .ENTRIES(6)
    ) u_table (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .wr_en(wr_en),
        .wr_idx(wr_idx),
        .wr_code(wr_code),
        .rd_flat_r(tbl)
    );

    // configuration writer: single writes, or an automatic fill of select bits
    always @*
    begin
        state_nxt = state_r;
        fill_idx_nxt = fill_idx_r;
        fill_code_nxt = fill_code_r;
        fill_left_nxt = fill_left_r;
        wr_en = 1'b0;
        wr_idx = CFG_INDEX;
        wr_code = CFG_FUNCTION;
        refused_nxt = 1'b0;
        case (state_r)
            ST_IDLE:
            begin
                if (CFG_SP_AUTO)
                begin
                    if (SP_ON_EXPANSION)
                        refused_nxt = 1'b1;
                    else
                    begin
                        state_nxt = ST_FILL;
                        fill_idx_nxt = `IDX_INPUT_SIX;
                        fill_code_nxt = `FN_SP_BIT0 + {3'h0, CFG_SP_MSB};
                        fill_left_nxt = {1'b0, CFG_SP_MSB} + 3'h1;
                    end
                end
                else if (CFG_PAT_AUTO)
                begin
                    if (!PROGRAM_CONTROL)
                        refused_nxt = 1'b1;
                    else
                    begin
                        state_nxt = ST_FILL;
                        fill_idx_nxt = bits_for(CFG_PAT_HIGHEST) - 3'h1;
                        fill_code_nxt = `FN_PAT_BIT0 + {2'h0, bits_for(CFG_PAT_HIGHEST)} - 5'h01;
                        fill_left_nxt = bits_for(CFG_PAT_HIGHEST);
                    end
                end
                else if (CFG_WRITE)
                begin
                    if (CFG_INDEX <= `IDX_INPUT_SIX &&
                        legal(tbl, CFG_INDEX, CFG_FUNCTION, CASCADE_CONTROL,
                              PROGRAM_CONTROL, SP_ON_EXPANSION))
                        wr_en = 1'b1;
                    else
                        refused_nxt = 1'b1;
                end
            end
            ST_FILL:
            begin
                wr_en = 1'b1;
                wr_idx = fill_idx_r;
                wr_code = fill_code_r;
                fill_idx_nxt = fill_idx_r - 3'h1;
                fill_code_nxt = fill_code_r - 5'h01;
                fill_left_nxt = fill_left_r - 3'h1;
                if (fill_left_r == 3'h1)
                    state_nxt = ST_IDLE;
            end
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state_r <= ST_IDLE;
            fill_idx_r <= 3'h0;
            fill_code_r <= 5'h00;
            fill_left_r <= 3'h0;
            CFG_REFUSED <= 1'b0;
            CFG_BUSY <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            fill_idx_r <= fill_idx_nxt;
            fill_code_r <= fill_code_nxt;
            fill_left_r <= fill_left_nxt;
            CFG_REFUSED <= refused_nxt;
            CFG_BUSY <= state_nxt == ST_FILL;
        end
    end

    // select bit levels gathered from their assigned contacts
    always @*
    begin
        sp_raw = 4'h0;
        pat_raw = 5'h00;
        for (m = 0; m < 6; m = m + 1)
        begin
            if (!SP_ON_EXPANSION && entry(tbl, m[2:0]) >= `FN_SP_BIT0 &&
                entry(tbl, m[2:0]) <= `FN_SP_BIT3)
                sp_raw = sp_raw | ({3'h0, lvl[m]} << (entry(tbl, m[2:0]) - `FN_SP_BIT0));
            if (PROGRAM_CONTROL && entry(tbl, m[2:0]) >= `FN_PAT_BIT0 &&
                entry(tbl, m[2:0]) <= `FN_PAT_BIT4)
                pat_raw = pat_raw | ({4'h0, lvl[m]} << (entry(tbl, m[2:0]) - `FN_PAT_BIT0));
        end
        if (SP_ON_EXPANSION)
            sp_raw = lvl[9:6];
    end

    // edge actions; slots are scanned in order, and a halt beats a run in one cycle
    always @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            LOOP_RUN <= 2'h0;
            LOOP_REMOTE <= 2'h0;
            LOOP_PROGRAM <= 2'h0;
            LOOP_AUTO <= 2'h3;
            CASCADE_STATE <= `CAS_AUTO;
            SETPOINT_NUMBER <= `SP_MIN;
            PATTERN_NUMBER <= `PAT_MIN;
            PROGRAM_BEGIN <= 1'b0;
            PROGRAM_CLEAR <= 1'b0;
            PROGRAM_HOLD <= 1'b0;
            PROGRAM_ADVANCE <= 1'b0;
        end
        else
        begin
            PROGRAM_BEGIN <= 1'b0;
            PROGRAM_CLEAR <= 1'b0;
            PROGRAM_HOLD <= 1'b0;
            PROGRAM_ADVANCE <= 1'b0;
            for (k = 0; k < 6; k = k + 1)
            begin
                case (entry(tbl, k[2:0]))
                    `FN_GLOBAL_RUN:
                        if (rise[k])
                            LOOP_RUN <= 2'h3;
                    `FN_RUN_STOP_1, `FN_RUN_STOP_2:
                    begin
                        if (rise[k])
                            LOOP_RUN[entry(tbl, k[2:0]) == `FN_RUN_STOP_2] <= 1'b0;
                        if (fall[k])
                            LOOP_RUN[entry(tbl, k[2:0]) == `FN_RUN_STOP_2] <= 1'b1;
                    end
                    `FN_REM_LOC_1, `FN_REM_LOC_2:
                    begin
                        if (rise[k] && PROGRAM_CONTROL)
                            LOOP_PROGRAM[entry(tbl, k[2:0]) == `FN_REM_LOC_2] <= 1'b1;
                        else if (rise[k])
                            LOOP_REMOTE[entry(tbl, k[2:0]) == `FN_REM_LOC_2] <= 1'b1;
                        if (fall[k])
                        begin
                            LOOP_PROGRAM[entry(tbl, k[2:0]) == `FN_REM_LOC_2] <= 1'b0;
                            LOOP_REMOTE[entry(tbl, k[2:0]) == `FN_REM_LOC_2] <= 1'b0;
                        end
                    end
                    `FN_AUTO_MAN_1, `FN_AUTO_MAN_2:
                    begin
                        if (!CASCADE_CONTROL && (rise[k] || fall[k]))
                            LOOP_AUTO[entry(tbl, k[2:0]) == `FN_AUTO_MAN_2] <= rise[k];
                    end
                    `FN_CASCADE_XFER:
                        if (CASCADE_CONTROL && rise[k])
                            CASCADE_STATE <= `CAS_CASCADE;
                    `FN_AUTO_XFER:
                        if (CASCADE_CONTROL && rise[k])
                            CASCADE_STATE <= `CAS_AUTO;
                    `FN_MANUAL_XFER:
                        if (CASCADE_CONTROL && rise[k])
                            CASCADE_STATE <= `CAS_MANUAL;
                    `FN_PROG_BEGIN:
                        PROGRAM_BEGIN <= PROGRAM_CONTROL & rise[k];
                    `FN_PROG_CLEAR:
                        PROGRAM_CLEAR <= PROGRAM_CONTROL & rise[k];
                    `FN_PROG_HOLD:
                        PROGRAM_HOLD <= PROGRAM_CONTROL & rise[k];
                    `FN_PROG_ADVANCE:
                        PROGRAM_ADVANCE <= PROGRAM_CONTROL & rise[k];
                    default:
                        ;
                endcase
            end
            // halt is applied last so it overrides any run in the same cycle
            for (k = 0; k < 6; k = k + 1)
            begin
                if (entry(tbl, k[2:0]) == `FN_GLOBAL_HALT && rise[k])
                    LOOP_RUN <= 2'h0;
            end
            // zero and overrange codes clamp into the legal number range
            if (sp_raw < `SP_MIN)
                SETPOINT_NUMBER <= `SP_MIN;
            else if (sp_raw > `SP_MAX)
                SETPOINT_NUMBER <= `SP_MAX;
            else
                SETPOINT_NUMBER <= sp_raw;
            if (pat_raw < `PAT_MIN)
                PATTERN_NUMBER <= `PAT_MIN;
            else if (pat_raw > `PAT_MAX)
                PATTERN_NUMBER <= `PAT_MAX;
            else
                PATTERN_NUMBER <= pat_raw;
        end
    end
endmodule
`default_nettype wire

// ==== core/contact_mapper_regs.vh ====
// constants shared by the contact input function mapper
`ifndef CONTACT_MAPPER_REGS_VH
`define CONTACT_MAPPER_REGS_VH
// contact source groups
`define SRC_CTL_INPUTS 3'h0
`define SRC_CTL_OUTPUTS 3'h1
`define SRC_SWITCH_A 3'h2
`define SRC_SWITCH_B 3'h3
`define SRC_SWITCH_C 3'h4
// function codes held per contact
`define FN_WIDTH 5
`define FN_NONE 5'h00
`define FN_GLOBAL_HALT 5'h01
`define FN_GLOBAL_RUN 5'h02
`define FN_RUN_STOP_1 5'h03
`define FN_RUN_STOP_2 5'h04
`define FN_REM_LOC_1 5'h05
`define FN_REM_LOC_2 5'h06
`define FN_AUTO_MAN_1 5'h07
`define FN_AUTO_MAN_2 5'h08
`define FN_CASCADE_XFER 5'h09
`define FN_AUTO_XFER 5'h0a
`define FN_MANUAL_XFER 5'h0b
`define FN_PROG_BEGIN 5'h0c
`define FN_PROG_CLEAR 5'h0d
`define FN_PROG_HOLD 5'h0e
`define FN_PROG_ADVANCE 5'h0f
`define FN_SP_BIT0 5'h10
`define FN_SP_BIT3 5'h13
`define FN_PAT_BIT0 5'h14
`define FN_PAT_BIT4 5'h18
// cascade pair operating states
`define CAS_MANUAL 2'h0
`define CAS_AUTO 2'h1
`define CAS_CASCADE 2'h2
// number ranges
`define SP_MIN 4'h1
`define SP_MAX 4'h8
`define PAT_MIN 5'h01
`define PAT_MAX 5'h1e
// contact positions
`define IDX_INPUT_ONE 3'h0
`define IDX_INPUT_THREE 3'h2
`define IDX_INPUT_FIVE 3'h4
`define IDX_INPUT_SIX 3'h5
// debounce time and clock
`define DEBOUNCE_US 10
`define CLK_PERIOD_NS 20
`define DEBOUNCE_CYC ((`DEBOUNCE_US * 1000) / `CLK_PERIOD_NS)
`endif

// ==== core/contact_debounce.v ====
// synchroniser, debounce filter and edge detector for one contact
`timescale 1ns/100ps
`default_nettype none
`include "contact_mapper_regs.vh"
module contact_debounce #(
    parameter STABLE_CYC = `DEBOUNCE_CYC
) (
    input wire clk,
    input wire rst_n,
    input wire raw,
    output reg level_r,
    output reg rise_r,
    output reg fall_r
);
    reg meta_r;
    reg sync_r;
    reg [12:0] cnt_r;

    // two flops; only sync_r is looked at
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end
        else
        begin
            meta_r <= raw;
            sync_r <= meta_r;
        end
    end

    // level accepted only after it stayed put the whole window, so bounce gives one edge
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r <= 13'h0000;
            level_r <= 1'b0;
            rise_r <= 1'b0;
            fall_r <= 1'b0;
        end
        else
        begin
            rise_r <= 1'b0;
            fall_r <= 1'b0;
            if (sync_r == level_r)
                cnt_r <= 13'h0000;
            else if (cnt_r == STABLE_CYC[12:0] - 13'h0001)
            begin
                cnt_r <= 13'h0000;
                level_r <= sync_r;
                rise_r <= sync_r;
                fall_r <= ~sync_r;
            end
            else
                cnt_r <= cnt_r + 13'h0001;
        end
    end
endmodule
`default_nettype wire

// ==== core/function_table.v ====
// small store of the function code assigned to each contact
`timescale 1ns/100ps
`default_nettype none
`include "contact_mapper_regs.vh"
module function_table #(
    parameter ENTRIES = 6
) (
    input wire clk,
    input wire rst_n,
    input wire wr_en,
    input wire [2:0] wr_idx,
    input wire [`FN_WIDTH-1:0] wr_code,
    output reg [ENTRIES*`FN_WIDTH-1:0] rd_flat_r
);
    integer i;

    // the table is its own read register, so every entry is readable at once
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rd_flat_r <= {ENTRIES*`FN_WIDTH{1'b0}};
        else
        begin
            for (i = 0; i < ENTRIES; i = i + 1)
            begin
                if (wr_en && wr_idx == i[2:0])
                    rd_flat_r[i*`FN_WIDTH +: `FN_WIDTH] <= wr_code;
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/contact_bank.sv ====
// dry contact and switch bank on the far side of the mapper
`timescale 1ns/100ps
`default_nettype none
module contact_bank (
    output wire logic [5:0] ctl_in,
    output wire logic [5:0] ctl_out,
    output wire logic [5:0] sw_a,
    output wire logic [5:0] sw_b,
    output wire logic [5:0] sw_c,
    output wire logic [3:0] exp_in
);
    // groups: 0 block inputs, 1 block outputs, 2..4 switches, 5 expansion
    logic [5:0] lvl [0:5] = '{default: 6'h00};
    assign ctl_in = lvl[0];
    assign ctl_out = lvl[1];
    assign sw_a = lvl[2];
    assign sw_b = lvl[3];
    assign sw_c = lvl[4];
    assign exp_in = lvl[5][3:0];
    // a closed contact reads 1; the bench makes any bounce itself
    task automatic set(input int g, input int b, input logic v);
        lvl[g][b] = v;
    endtask
endmodule
`default_nettype wire

// ==== tb/contact_mapper_sva.sv ====
// port checker for the contact input function mapper
`timescale 1ns/100ps
`default_nettype none
`include "contact_mapper_regs.vh"
module mapper_sva (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic CASCADE_CONTROL,
    input wire logic PROGRAM_CONTROL,
    input wire logic SP_ON_EXPANSION,
    input wire logic CFG_WRITE,
    input wire logic [2:0] CFG_INDEX,
    input wire logic [4:0] CFG_FUNCTION,
    input wire logic CFG_SP_AUTO,
    input wire logic CFG_PAT_AUTO,
    input wire logic CFG_REFUSED,
    input wire logic CFG_BUSY,
    input wire logic [3:0] SETPOINT_NUMBER,
    input wire logic [4:0] PATTERN_NUMBER
);
    // a plain write that the port takes, and the code classes it may carry
    wire logic wr_take = CFG_WRITE && !CFG_SP_AUTO && !CFG_PAT_AUTO && !CFG_BUSY;
    wire logic am_code = CFG_FUNCTION == `FN_AUTO_MAN_1 || CFG_FUNCTION == `FN_AUTO_MAN_2;
    wire logic pg_code = CFG_FUNCTION >= `FN_PROG_BEGIN && CFG_FUNCTION <= `FN_PROG_ADVANCE;
    default clocking @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_N);
    a_sp_range: assert property (SETPOINT_NUMBER >= `SP_MIN && SETPOINT_NUMBER <= `SP_MAX)
        else $error("setpoint number out of range");
    a_pat_range: assert property (PATTERN_NUMBER >= `PAT_MIN && PATTERN_NUMBER <= `PAT_MAX)
        else $error("pattern number out of range");
    // a fill writes one slot a cycle, five slots at most
    a_fill_bound: assert property ($rose(CFG_BUSY) |-> ##[1:5] !CFG_BUSY)
        else $error("fill ran too long");
    a_sp_fill: assert property (CFG_SP_AUTO && !CFG_BUSY && !SP_ON_EXPANSION |=> CFG_BUSY)
        else $error("setpoint fill did not start");
    a_sp_single: assert property (CFG_SP_AUTO && !CFG_BUSY && SP_ON_EXPANSION |=> CFG_REFUSED)
        else $error("second setpoint group accepted");
    a_pat_gate: assert property (!PROGRAM_CONTROL && CFG_PAT_AUTO && !CFG_SP_AUTO
        && !CFG_BUSY |=> CFG_REFUSED) else $error("pattern fill outside program control");
    a_bad_slot: assert property (wr_take && CFG_INDEX > 3'h5 |=> CFG_REFUSED)
        else $error("write to missing slot accepted");
    a_am_cascade: assert property (wr_take && CASCADE_CONTROL && am_code |=> CFG_REFUSED)
        else $error("auto manual taken in cascade");
    a_prog_gate: assert property (wr_take && !PROGRAM_CONTROL && pg_code |=> CFG_REFUSED)
        else $error("program function taken outside program control");
    a_xfer_gate: assert property (wr_take && !CASCADE_CONTROL
        && CFG_FUNCTION == `FN_CASCADE_XFER |=> CFG_REFUSED) else $error("transfer outside cascade");
    // main scenarios reached
    c_fill: cover property ($fell(CFG_BUSY));
    c_refuse: cover property (CFG_REFUSED);
    c_top_pattern: cover property (PATTERN_NUMBER == `PAT_MAX);
endmodule
bind contact_input_function_mapper mapper_sva u_mapper_sva (.CORE_CLK, .RST_N, .CASCADE_CONTROL,
    .PROGRAM_CONTROL, .SP_ON_EXPANSION, .CFG_WRITE, .CFG_INDEX, .CFG_FUNCTION, .CFG_SP_AUTO,
    .CFG_PAT_AUTO, .CFG_REFUSED, .CFG_BUSY, .SETPOINT_NUMBER, .PATTERN_NUMBER);
`default_nettype wire

// ==== tb/contact_input_function_mapper_bench.sv ====
// self-checking bench for the contact input function mapper
`timescale 1ns/100ps
`default_nettype none
`include "contact_mapper_regs.vh"
module contact_input_function_mapper_bench;
    localparam int STABLE = 4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cas = 1'b0;
    logic prog = 1'b0;
    logic sp_exp = 1'b0;
    logic [2:0] src = 3'h0;
    logic [2:0] kind = 3'h0;
    logic [2:0] idx = 3'h0;
    logic [4:0] arg = 5'h00;
    logic [3:0] seen = 4'h0;
    wire [5:0] ctl_in, ctl_out, sw_a, sw_b, sw_c;
    wire [3:0] exp_in, sp;
    wire [4:0] pat;
    wire [1:0] run, rem, pgm, am, cst;
    wire refd, busy, pb, pc, ph, pa;
    int failures = 0;
    int checks = 0;
    always #10 clk = ~clk;
    // program pulses last one cycle, so they are latched here
    always @(posedge clk)
        seen <= seen | {pa, ph, pc, pb};
    contact_bank i_contact_bank (.ctl_in, .ctl_out, .sw_a, .sw_b, .sw_c, .exp_in);
    contact_input_function_mapper #(.STABLE_CYC(STABLE)) i_contact_input_function_mapper (
        .CORE_CLK(clk), .RST_N(rst_n), .CTL_BLOCK_INPUTS(ctl_in), .CTL_BLOCK_OUTPUTS(ctl_out),
        .INTERNAL_SWITCH_GROUP_A(sw_a), .INTERNAL_SWITCH_GROUP_B(sw_b),
        .INTERNAL_SWITCH_GROUP_C(sw_c), .EXPANSION_INPUTS(exp_in), .SOURCE_SELECT(src),
        .CASCADE_CONTROL(cas), .PROGRAM_CONTROL(prog), .SP_ON_EXPANSION(sp_exp),
        .CFG_WRITE(kind[0]), .CFG_INDEX(idx), .CFG_FUNCTION(arg), .CFG_SP_AUTO(kind[1]),
        .CFG_SP_MSB(arg[1:0]), .CFG_PAT_AUTO(kind[2]), .CFG_PAT_HIGHEST(arg),
        .CFG_REFUSED(refd), .CFG_BUSY(busy), .LOOP_RUN(run), .LOOP_REMOTE(rem),
        .LOOP_PROGRAM(pgm), .LOOP_AUTO(am), .CASCADE_STATE(cst), .SETPOINT_NUMBER(sp),
        .PATTERN_NUMBER(pat), .PROGRAM_BEGIN(pb), .PROGRAM_CLEAR(pc), .PROGRAM_HOLD(ph),
        .PROGRAM_ADVANCE(pa));
    task automatic finish_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        checks++;
        if (got !== want)
        begin
            failures++;
            $display("BAD at %0t: got %h want %h", $time, got, want);
        end
    endtask
    // one config request: kind 1 write, 2 setpoint fill, 4 pattern fill
    task automatic req(input logic [2:0] k, input logic [4:0] a, input logic [2:0] s,
        input logic r);
        int n;
        @(negedge clk);
        kind = k;
        arg = a;
        idx = s;
        @(negedge clk);
        kind = 3'h0;
        chk(refd, r);
        for (n = 0; n < 9 && busy !== 1'b0; n++)
            @(negedge clk);
        if (n == 9)
        begin
            failures++;
            finish_test();
        end
    endtask
    // move one contact and give the filter time to pass it
    task automatic hit(input int g, input int b, input logic v);
        @(negedge clk);
        i_contact_bank.set(g, b, v);
        repeat (STABLE + 8) @(negedge clk);
    endtask
    task automatic pattern(input logic [4:0] v);
        for (int k = 0; k < 5; k++)
            hit(0, k, v[k]);
    endtask
    initial
    begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        chk({run, rem, pgm, am}, 8'h03);
        chk({cst, sp}, 8'h11);
        chk(pat, 8'h01);
        // switch group a is the source; block inputs must be ignored meanwhile
        src = 3'h2;
        req(1, `FN_GLOBAL_RUN, 1, 0);
        req(1, `FN_GLOBAL_RUN, 6, 1);
        hit(0, 1, 1'b1);
        chk(run, 8'h00);
        hit(2, 1, 1'b1);
        chk(run, 8'h03);
        hit(2, 1, 1'b0);
        hit(0, 1, 1'b0);
        src = 3'h0;
        $display("test source done");
        req(1, `FN_RUN_STOP_1, 0, 0);
        req(1, `FN_GLOBAL_HALT, 2, 0);
        hit(0, 0, 1'b1);
        chk(run, 8'h02);
        hit(0, 0, 1'b0);
        chk(run, 8'h03);
        hit(0, 2, 1'b1);
        chk(run, 8'h00);
        // a two cycle blip shorter than the filter must not start the loops
        @(negedge clk);
        i_contact_bank.set(0, 1, 1'b1);
        @(negedge clk);
        hit(0, 1, 1'b0);
        chk(run, 8'h00);
        $display("test run stop done");
        req(1, `FN_REM_LOC_1, 3, 0);
        hit(0, 3, 1'b1);
        chk({pgm, rem}, 8'h01);
        hit(0, 3, 1'b0);
        prog = 1'b1;
        hit(0, 3, 1'b1);
        chk({pgm, rem}, 8'h04);
        hit(0, 3, 1'b0);
        chk({pgm, rem}, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            req(1, `FN_PROG_BEGIN + 5'(k), 5, 0);
            hit(0, 5, 1'b1);
            chk(seen, (8'h02 << k) - 8'h01);
            hit(0, 5, 1'b0);
        end
        prog = 1'b0;
        req(1, `FN_PROG_HOLD, 5, 1);
        $display("test remote and program done");
        req(1, `FN_AUTO_MAN_2, 4, 0);
        hit(0, 4, 1'b1);
        hit(0, 4, 1'b0);
        chk(am, 8'h01);
        hit(0, 4, 1'b1);
        chk(am, 8'h03);
        req(1, `FN_CASCADE_XFER, 0, 1);
        cas = 1'b1;
        req(1, `FN_AUTO_MAN_1, 0, 1);
        req(1, `FN_RUN_STOP_1, 0, 1);
        req(1, `FN_CASCADE_XFER, 0, 0);
        req(1, `FN_AUTO_XFER, 1, 0);
        req(1, `FN_MANUAL_XFER, 3, 0);
        req(1, `FN_MANUAL_XFER, 4, 1);
        hit(0, 0, 1'b1);
        chk(cst, 8'h02);
        hit(0, 3, 1'b1);
        chk(cst, 8'h00);
        hit(0, 1, 1'b1);
        chk(cst, 8'h01);
        cas = 1'b0;
        $display("test cascade done");
        req(1, `FN_SP_BIT0, 0, 1);
        sp_exp = 1'b1;
        req(2, 5'h03, 0, 1);
        hit(5, 2, 1'b1);
        chk(sp, 8'h04);
        sp_exp = 1'b0;
        req(2, 5'h03, 0, 0);
        hit(0, 2, 1'b0);
        chk(sp, 8'h06);
        hit(0, 5, 1'b1);
        chk(sp, 8'h08);
        $display("test setpoint done");
        req(4, 5'h1e, 0, 1);
        prog = 1'b1;
        req(4, 5'h1e, 0, 0);
        pattern(5'h06);
        chk(pat, 8'h06);
        pattern(5'h1f);
        chk(pat, 8'h1e);
        $display("test pattern done");
        finish_test();
    end
endmodule
`default_nettype wire
